/* design/fep_top.sv */
/*
  Flash error flags and program flash protection, with an Avalon-MM register slave.
  Assumes the command engine, the array read path and the reset fetch port outside.
*/
`timescale 1ns/1ps
`default_nettype none
module fep_top
  import fep_pkg::*;
#(
  parameter logic [22:0] PFLASH_BASE = 23'h40_0000
)(
  // Clock, reset and enable.
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Avalon-MM register slave.
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Array read events.
  input  wire fep_rd_evt_s rd_evt,
  // Reset time fetch of the protection byte.
  output logic             nv_fetch_req,
  output logic [22:0]      nv_fetch_addr,
  input  wire logic        nv_done,
  input  wire logic [7:0]  nv_data,
  input  wire logic        nv_dfault,
  // Program and erase check.
  input  wire fep_cmd_s    cmd,
  output logic             cmd_done,
  output logic             cmd_refused,
  // Interrupt requests.
  output logic             irq_double,
  output logic             irq_single
);

  logic [1:0]  rst_pipe_ff;
  logic        srst_n;
  logic        waitreq_ff;
  logic        nxt_waitreq;
  logic [31:0] readdata_ff;
  logic [7:0]  err_flags_ff;
  logic [7:0]  nxt_err_flags;
  logic [7:0]  err_cfg_ff;
  logic [7:0]  flash_cfg_ff;
  logic [7:0]  main_stat_ff;
  logic [7:0]  nxt_main_stat;
  logic [7:0]  prot_ff;
  logic [7:0]  nxt_prot;
  fep_state_e  state_ff;
  logic        fetch_req_ff;
  logic [22:0] fetch_addr_ff;
  logic        cmd_done_ff;
  logic        cmd_refused_ff;
  logic        irq_double_ff;
  logic        irq_single_ff;

  // Reset release through two flip-flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_ff <= 2'b00;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end
  assign srst_n = rst_pipe_ff[1];

  // Bus decode.
  logic       bus_req;
  logic       bus_ack;
  logic       bus_take;
  logic [3:0] bus_idx;
  logic       bus_aligned;
  logic       wr_lane;
  logic [7:0] wd;
  logic       hit_fcfg;
  logic       hit_ecfg;
  logic       hit_mstat;
  logic       hit_eflags;
  logic       hit_prot;
  logic       wr_fcfg;
  logic       wr_ecfg;
  logic       wr_mstat;
  logic       wr_eflags;
  logic       wr_prot;
  logic [7:0] rd_byte;

  assign bus_req     = avs_read | avs_write;
  assign bus_take    = bus_req & waitreq_ff;
  assign bus_ack     = bus_req & ~waitreq_ff;
  assign bus_idx     = avs_address[5:2];
  assign bus_aligned = avs_address[1:0] == 2'b00;
  assign wr_lane     = avs_write & bus_ack & avs_byteenable[0];
  assign wd          = avs_writedata[7:0];
  assign hit_fcfg    = bus_aligned & (bus_idx == IDX_FLASH_CFG);
  assign hit_ecfg    = bus_aligned & (bus_idx == IDX_ERR_CFG);
  assign hit_mstat   = bus_aligned & (bus_idx == IDX_MAIN_STAT);
  assign hit_eflags  = bus_aligned & (bus_idx == IDX_ERR_FLAGS);
  assign hit_prot    = bus_aligned & (bus_idx == IDX_PROT);
  assign wr_fcfg     = wr_lane & hit_fcfg;
  assign wr_ecfg     = wr_lane & hit_ecfg;
  assign wr_mstat    = wr_lane & hit_mstat;
  assign wr_eflags   = wr_lane & hit_eflags;
  assign wr_prot     = wr_lane & hit_prot & (state_ff == FEP_RUN);

  assign rd_byte = ({8{hit_fcfg}}   & flash_cfg_ff)
                 | ({8{hit_ecfg}}   & err_cfg_ff)
                 | ({8{hit_mstat}}  & main_stat_ff)
                 | ({8{hit_eflags}} & err_flags_ff)  // RQ22
                 | ({8{hit_prot}}   & prot_ff);      // RQ17

  // One wait cycle, then a single cycle with waitrequest low.
  assign nxt_waitreq = ~bus_take;

  always_ff @(posedge clock) begin
    if (!srst_n) begin
      waitreq_ff  <= 1'b1;
      readdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      waitreq_ff <= nxt_waitreq;
      if (bus_take && avs_read) begin
        readdata_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Error flags: the set of a new event wins over a clear.
  logic set_dbl;
  logic set_sgl;
  logic ignore_single_fault;

  assign ignore_single_fault = flash_cfg_ff[IGNORE_SINGLE_FAULT_BIT];
  assign set_dbl = rd_evt.valid & (rd_evt.double_bit | rd_evt.busy_block); // RQ2
  assign set_sgl = rd_evt.valid & ~ignore_single_fault
                 & (rd_evt.single_bit | rd_evt.busy_block);               // RQ3

  always_comb begin
    nxt_err_flags = REG_RST; // RQ22
    nxt_err_flags[DFLT_BIT] = set_dbl
      | (err_flags_ff[DFLT_BIT] & ~(wr_eflags & wd[DFLT_BIT])); // RQ1
    nxt_err_flags[SFLT_BIT] = set_sgl
      | (err_flags_ff[SFLT_BIT] & ~(wr_eflags & wd[SFLT_BIT])); // RQ1
  end

  // Protection write: size fields gated by their disable bits.
  logic [1:0] cand_hs;
  logic [1:0] cand_ls;
  logic [7:0] prot_cand;
  logic [2:0] scn_from;
  logic [2:0] scn_to;
  logic       trans_ok;

  assign cand_hs = prot_ff[HDIS_BIT] ? wd[HS_MSB:HS_LSB] : prot_ff[HS_MSB:HS_LSB]; // RQ11
  assign cand_ls = prot_ff[LDIS_BIT] ? wd[LS_MSB:LS_LSB] : prot_ff[LS_MSB:LS_LSB]; // RQ14
  assign prot_cand = {wd[7:5], cand_hs, wd[LDIS_BIT], cand_ls};
  assign scn_from = {prot_ff[POPEN_BIT], prot_ff[HDIS_BIT], prot_ff[LDIS_BIT]};       // RQ21
  assign scn_to   = {prot_cand[POPEN_BIT], prot_cand[HDIS_BIT], prot_cand[LDIS_BIT]}; // RQ21
  assign trans_ok = SCN_ALLOWED[scn_from][scn_to]; // RQ16

  always_comb begin
    nxt_prot = prot_ff;
    if (state_ff == FEP_FETCH && nv_done) begin
      nxt_prot = nv_dfault ? PROT_FULL : nv_data; // RQ4 RQ5
    end else if (wr_prot && trans_ok) begin
      nxt_prot = prot_cand; // RQ16
    end
  end

  // Program and erase check against the protection in force.
  logic addr_prot;
  logic any_prot;
  logic in_pflash;
  logic cmd_refuse;

  fep_range_check u_range (
    .prot      (prot_ff),
    .addr      (cmd.addr),
    .addr_prot (addr_prot),
    .any_prot  (any_prot)
  );

  assign in_pflash  = cmd.addr >= PFLASH_BASE;
  assign cmd_refuse = cmd.valid & ((state_ff == FEP_FETCH)
                    | (in_pflash & (cmd.blk_erase ? any_prot : addr_prot))); // RQ6 RQ7

  always_comb begin
    nxt_main_stat = REG_RST;
    nxt_main_stat[PVIOL_BIT] = cmd_refuse
      | (main_stat_ff[PVIOL_BIT] & ~(wr_mstat & wd[PVIOL_BIT])); // RQ6
  end

  // Register state.
  always_ff @(posedge clock) begin
    if (!srst_n) begin
      err_flags_ff <= REG_RST;
      err_cfg_ff   <= REG_RST;
      flash_cfg_ff <= REG_RST;
      main_stat_ff <= REG_RST;
      prot_ff      <= PROT_FULL;
    end else if (clk_en) begin
      err_flags_ff <= nxt_err_flags;
      main_stat_ff <= nxt_main_stat;
      prot_ff      <= nxt_prot;
      if (wr_ecfg) begin
        err_cfg_ff <= wd & 8'h03;
      end
      if (wr_fcfg) begin
        flash_cfg_ff <= wd & 8'h10;
      end
    end
  end

  // Reset sequence fetch, then normal running.
  always_ff @(posedge clock) begin
    if (!srst_n) begin
      state_ff      <= FEP_FETCH;
      fetch_req_ff  <= 1'b0;
      fetch_addr_ff <= NV_PROT_ADDR; // RQ4
    end else if (clk_en) begin
      unique case (state_ff)
        FEP_FETCH: begin
          fetch_req_ff <= ~nv_done; // RQ4
          if (nv_done) begin
            state_ff <= FEP_RUN;
          end
        end
        FEP_RUN: begin
          fetch_req_ff <= 1'b0;
        end
      endcase
    end
  end

  // Command answer and interrupt requests.
  always_ff @(posedge clock) begin
    if (!srst_n) begin
      cmd_done_ff    <= 1'b0;
      cmd_refused_ff <= 1'b0;
      irq_double_ff  <= 1'b0;
      irq_single_ff  <= 1'b0;
    end else if (clk_en) begin
      cmd_done_ff    <= cmd.valid;
      cmd_refused_ff <= cmd_refuse;
      irq_double_ff  <= err_flags_ff[DFLT_BIT] & err_cfg_ff[DFLT_BIT]; // RQ19
      irq_single_ff  <= err_flags_ff[SFLT_BIT] & err_cfg_ff[SFLT_BIT]; // RQ20
    end
  end

  assign avs_readdata    = readdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign nv_fetch_req    = fetch_req_ff;
  assign nv_fetch_addr   = fetch_addr_ff;
  assign cmd_done        = cmd_done_ff;
  assign cmd_refused     = cmd_refused_ff;
  assign irq_double      = irq_double_ff;
  assign irq_single      = irq_single_ff;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!srst_n);

  sequence s_bus_wait;
    clk_en && bus_take;
  endsequence

  sequence s_bus_answer;
    !waitreq_ff ##1 (waitreq_ff || !$past(clk_en));
  endsequence

  a_bus_answer_cycle: assert property (s_bus_wait |=> s_bus_answer) // RQ17
    else $error("Bus answer not given one cycle after the request.");

  a_dbl_flag_set: assert property (clk_en && set_dbl |=> err_flags_ff[DFLT_BIT]) // RQ2
    else $error("Double fault flag not set by a read event.");

  a_sgl_flag_ignored: assert property ( // RQ3
    clk_en && ignore_single_fault && !err_flags_ff[SFLT_BIT] |=> !err_flags_ff[SFLT_BIT])
    else $error("Single fault flag set while ignored.");

  a_sgl_flag_set: assert property (clk_en && set_sgl |=> err_flags_ff[SFLT_BIT]) // RQ3
    else $error("Single fault flag not set by a read event.");

  a_flag_w1c_clear: assert property ( // RQ1
    clk_en && wr_eflags && wd[DFLT_BIT] && !set_dbl |=> !err_flags_ff[DFLT_BIT])
    else $error("Double fault flag not cleared by a one.");

  a_flag_unused_zero: assert property (err_flags_ff[7:2] == 6'h00) // RQ22
    else $error("Unused error flag bits not zero.");

  a_prot_bad_write: assert property ( // RQ16
    clk_en && wr_prot && !trans_ok && state_ff == FEP_RUN |=> $stable(prot_ff))
    else $error("Forbidden protection transition accepted.");

  a_prot_scn_legal: assert property ( // RQ16
    clk_en && state_ff == FEP_RUN |=> SCN_ALLOWED[$past(scn_from)][scn_from])
    else $error("Protection scenario moved along a forbidden transition.");

  a_high_size_lock: assert property ( // RQ11
    clk_en && wr_prot && !prot_ff[HDIS_BIT] |=> $stable(prot_ff[HS_MSB:HS_LSB]))
    else $error("High size written while high range enabled.");

  a_low_size_lock: assert property ( // RQ14
    clk_en && wr_prot && !prot_ff[LDIS_BIT] |=> $stable(prot_ff[LS_MSB:LS_LSB]))
    else $error("Low size written while low range enabled.");

  a_fetch_load_byte: assert property ( // RQ4
    clk_en && state_ff == FEP_FETCH && nv_done && !nv_dfault
    |=> prot_ff == $past(nv_data) && state_ff == FEP_RUN)
    else $error("Fetched protection byte not loaded.");

  a_fetch_fault_full: assert property ( // RQ5
    clk_en && state_ff == FEP_FETCH && nv_done && nv_dfault
    |=> prot_ff == PROT_FULL && state_ff == FEP_RUN)
    else $error("Faulted fetch did not protect all flash.");

  a_fetch_cmd_refused: assert property ( // RQ6
    clk_en && state_ff == FEP_FETCH && cmd.valid |=> cmd_refused_ff)
    else $error("Command accepted before the protection byte was loaded.");

  a_refuse_flags_viol: assert property ( // RQ6
    clk_en && cmd_refuse |=> cmd_refused_ff && cmd_done_ff && main_stat_ff[PVIOL_BIT])
    else $error("Refused command did not flag a violation.");

  a_viol_flag_clear: assert property ( // RQ6
    clk_en && wr_mstat && wd[PVIOL_BIT] && !cmd_refuse |=> !main_stat_ff[PVIOL_BIT])
    else $error("Violation flag not cleared by a one.");

  a_full_prot_erase: assert property ( // RQ7
    clk_en && cmd.valid && cmd.blk_erase && in_pflash && any_prot |=> cmd_refused_ff)
    else $error("Block erase accepted with protected sectors.");

  a_irq_double_req: assert property ( // RQ19
    clk_en && err_flags_ff[DFLT_BIT] && err_cfg_ff[DFLT_BIT] |=> irq_double_ff)
    else $error("Double fault interrupt not requested.");

  a_irq_single_req: assert property ( // RQ20
    clk_en && !(err_flags_ff[SFLT_BIT] && err_cfg_ff[SFLT_BIT]) |=> !irq_single_ff)
    else $error("Single fault interrupt without flag and enable.");

endmodule : fep_top
`default_nettype wire

/* design/fep_pkg.sv */
/*
  Shared constants, types and register map of the flash error and protection block.
  Assumes one 40 MHz clock and word-aligned byte addresses on the register bus.
*/
// Overview of operation
// (RQ1) Error flags are readable; writing one clears a flag, zero leaves it.
// (RQ2) Double fault flag bit 1 sets on two-bit error or read of busy block.
// (RQ3) Single fault flag bit 0 sets on corrected error or busy read, unless ignored.
// (RQ4) Protection register loads the nonvolatile protection byte during the reset sequence.
// (RQ5) A double fault on that load leaves program flash fully protected.
// (RQ6) Program or erase of a protected address is refused and flags a violation.
// (RQ7) Block erase is refused while any sector of the block is protected.
// (RQ8) Bit 7 chooses whether enabled ranges are protected or unprotected.
// (RQ9) Bit 5 disables the high range that ends at the top of flash.
// (RQ10) Bits 4:3 size the high range at 2, 4, 8 or 16 KB.
// (RQ11) High size bits take writes only while the high range is disabled.
// (RQ12) Bit 2 disables the low range that starts at the protectable base.
// (RQ13) Bits 1:0 size the low range at 1, 2, 4 or 8 KB.
// (RQ14) Low size bits take writes only while the low range is disabled.
// (RQ15) Bit 7 and both disables set protect nothing; bit 7 clear with both disables set protects all.
// (RQ16) A write leading to a forbidden scenario transition is ignored.
// (RQ17) Reading the protection register returns the scenario in force.
// (RQ18) Software should leave reserved bit 6 in its erased state.
// (RQ19) Double fault interrupt requests while its flag and enable are set.
// (RQ20) Single fault interrupt requests while its flag and enable are set.
// (RQ21) Scenario number is operation enable, high disable, low disable, in that order.
// (RQ22) Unused error flag bits read zero and ignore writes.
package fep_pkg;

  localparam logic [3:0] IDX_FLASH_CFG = 4'h4;
  localparam logic [3:0] IDX_ERR_CFG   = 4'h5;
  localparam logic [3:0] IDX_MAIN_STAT = 4'h6;
  localparam logic [3:0] IDX_ERR_FLAGS = 4'h7;
  localparam logic [3:0] IDX_PROT      = 4'h8;

  localparam int DFLT_BIT  = 1;
  localparam int SFLT_BIT  = 0;
  localparam int IGNORE_SINGLE_FAULT_BIT = 4;
  localparam int PVIOL_BIT = 4;
  localparam int POPEN_BIT = 7;
  localparam int HDIS_BIT  = 5;
  localparam int HS_MSB    = 4;
  localparam int HS_LSB    = 3;
  localparam int LDIS_BIT  = 2;
  localparam int LS_MSB    = 1;
  localparam int LS_LSB    = 0;

  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] PROT_FULL = 8'h7f;

  localparam logic [22:0] NV_PROT_ADDR = 23'h7f_ff0c;
  localparam logic [22:0] HIGH_TOP     = 23'h7f_ffff;
  localparam logic [22:0] LOW_BASE     = 23'h7f_8000;
  localparam logic [23:0] HIGH_MIN     = 24'h00_0800;
  localparam logic [23:0] LOW_MIN      = 24'h00_0400;
  localparam logic [23:0] ONE24        = 24'h00_0001;

  // Row is the scenario in force, bit is the requested scenario.
  localparam logic [7:0][7:0] SCN_ALLOWED = {8'hff, 8'h5a, 8'h3c, 8'h18,
                                             8'h08, 8'h0c, 8'h0a, 8'h0f};

  typedef struct packed {
    logic valid;
    logic single_bit;
    logic double_bit;
    logic busy_block;
  } fep_rd_evt_s;

  typedef struct packed {
    logic        valid;
    logic        blk_erase;
    logic [22:0] addr;
  } fep_cmd_s;

  typedef enum logic [0:0] {FEP_FETCH, FEP_RUN} fep_state_e;

endpackage : fep_pkg

/* design/fep_range_check.sv */
/*
  Program flash range check: says whether an address is protected and whether any sector is.
  Assumes the protection byte comes straight from the protection register.
*/
`timescale 1ns/1ps
`default_nettype none
module fep_range_check
  import fep_pkg::*;
(
  // Protection setting.
  input  wire logic [7:0]  prot,
  // Address under test.
  input  wire logic [22:0] addr,
  // Results.
  output logic             addr_prot,
  output logic             any_prot
);

  logic [23:0] high_base;
  logic [23:0] low_end;
  logic [23:0] addr_x;
  logic        in_high;
  logic        in_low;

  assign addr_x    = {1'b0, addr};
  assign high_base = {1'b0, HIGH_TOP} + ONE24 - (HIGH_MIN << prot[HS_MSB:HS_LSB]); // RQ10
  assign low_end   = {1'b0, LOW_BASE} + (LOW_MIN << prot[LS_MSB:LS_LSB]) - ONE24;  // RQ13
  assign in_high   = ~prot[HDIS_BIT] & (addr_x >= high_base) & (addr <= HIGH_TOP); // RQ9
  assign in_low    = ~prot[LDIS_BIT] & (addr >= LOW_BASE) & (addr_x <= low_end);   // RQ12
  assign addr_prot = prot[POPEN_BIT] ? (in_high | in_low) : ~(in_high | in_low);   // RQ8
  assign any_prot  = ~(prot[POPEN_BIT] & prot[HDIS_BIT] & prot[LDIS_BIT]);        // RQ15

endmodule : fep_range_check
`default_nettype wire

/* bench/testbench.sv */
/*
  Self-checking testbench for the flash error and protection block.
  Assumes the block's own register slave timing and the fetch handshake described for its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fep_pkg::*;

  logic        clock         = 1'b0;
  logic        rst_n         = 1'b0;
  logic [5:0]  avs_address   = 6'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  fep_rd_evt_s rd_evt        = '0;
  logic        nv_fetch_req;
  logic [22:0] nv_fetch_addr;
  logic        nv_done       = 1'b0;
  logic [7:0]  nv_data       = 8'h00;
  logic        nv_dfault     = 1'b0;
  fep_cmd_s    cmd           = '0;
  logic        cmd_done;
  logic        cmd_refused;
  logic        irq_double;
  logic        irq_single;
  int          miscompares   = 0;
  int          check_count   = 0;
  logic [7:0]  q;
  logic [32:0] ent;

  // Allowed target scenarios for each scenario in force, one bit per target.
  localparam logic [7:0] ALLOW [0:7] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
  // Protection byte, block erase, address, expected refusal.
  localparam logic [32:0] CMD_TAB [0:22] = '{
    {8'h84, 1'b0, 23'h7ff800, 1'b1}, {8'h84, 1'b0, 23'h7ff7ff, 1'b0},
    {8'h8c, 1'b0, 23'h7ff000, 1'b1}, {8'h8c, 1'b0, 23'h7fefff, 1'b0},
    {8'h94, 1'b0, 23'h7fe000, 1'b1}, {8'h94, 1'b0, 23'h7fdfff, 1'b0},
    {8'h9c, 1'b0, 23'h7fc000, 1'b1}, {8'h9c, 1'b0, 23'h7fbfff, 1'b0},
    {8'ha0, 1'b0, 23'h7f83ff, 1'b1}, {8'ha0, 1'b0, 23'h7f8400, 1'b0},
    {8'ha1, 1'b0, 23'h7f87ff, 1'b1}, {8'ha1, 1'b0, 23'h7f8800, 1'b0},
    {8'ha2, 1'b0, 23'h7f8fff, 1'b1}, {8'ha2, 1'b0, 23'h7f9000, 1'b0},
    {8'ha3, 1'b0, 23'h7f9fff, 1'b1}, {8'ha3, 1'b0, 23'h7fa000, 1'b0},
    {8'h20, 1'b0, 23'h7f8000, 1'b0}, {8'h20, 1'b0, 23'h7f8400, 1'b1},
    {8'h24, 1'b0, 23'h500000, 1'b1}, {8'h24, 1'b0, 23'h000100, 1'b0},
    {8'he4, 1'b0, 23'h7fffff, 1'b0}, {8'he4, 1'b1, 23'h7f0000, 1'b0},
    {8'he0, 1'b1, 23'h7f0000, 1'b1}};

  always #12.5 clock = ~clock;

  fep_top dut_u (
    .clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rd_evt(rd_evt),
    .nv_fetch_req(nv_fetch_req), .nv_fetch_addr(nv_fetch_addr), .nv_done(nv_done),
    .nv_data(nv_data), .nv_dfault(nv_dfault), .cmd(cmd), .cmd_done(cmd_done),
    .cmd_refused(cmd_refused), .irq_double(irq_double), .irq_single(irq_single)
  );

  task automatic tally_and_finish();
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      $display("Error avs_waitrequest expected 0 seen %b", avs_waitrequest);
      miscompares++;
      tally_and_finish();
    end
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask : rd

  task automatic ev(input fep_rd_evt_s e);
    @(posedge clock);
    rd_evt <= e;
    @(posedge clock);
    rd_evt <= '0;
  endtask : ev

  task automatic cmdchk(input logic [22:0] a, input logic be, input logic e);
    int n;
    @(posedge clock);
    cmd <= '{1'b1, be, a};
    @(posedge clock);
    cmd <= '0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (cmd_done !== 1'b1 && n < 10);
    chk("cmd_done", 32'h1, {31'h0, cmd_done});
    chk("cmd_refused", {31'h0, e}, {31'h0, cmd_refused});
  endtask : cmdchk

  task automatic do_reset(input logic [7:0] nv, input logic df, input bit first);
    int n;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    n = 0;
    while (nv_fetch_req !== 1'b1 && n < 10) begin
      @(posedge clock);
      n++;
    end
    chk("nv_fetch_req", 32'h1, {31'h0, nv_fetch_req});
    chk("nv_fetch_addr", 32'h007f_ff0c, {9'h0, nv_fetch_addr});
    rd(6'h20, 8'h7f, "protection before fetch");
    if (first) begin
      cmdchk(23'h000100, 1'b0, 1'b1);
    end
    @(posedge clock);
    nv_done   <= 1'b1;
    nv_data   <= nv;
    nv_dfault <= df;
    @(posedge clock);
    nv_done <= 1'b0;
  endtask : do_reset

  function automatic logic [7:0] scn(input logic [2:0] s);
    return {s[2], 1'b1, s[1], 2'b00, s[0], 2'b00};
  endfunction : scn

  initial begin
    do_reset(8'hff, 1'b0, 1'b1);
    rd(6'h20, 8'hff, "protection after fetch");
    do_reset(8'hff, 1'b1, 1'b0);
    rd(6'h20, 8'h7f, "protection after faulty fetch");
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        do_reset(scn(3'(f)), 1'b0, 1'b0);
        wr(6'h20, scn(3'(t)));
        rd(6'h20, ALLOW[f][t] ? scn(3'(t)) : scn(3'(f)), "scenario");
      end
    end
    do_reset(8'he4, 1'b0, 1'b0);
    wr(6'h20, 8'hff);
    rd(6'h20, 8'hff, "size fields open");
    wr(6'h20, 8'hc0);
    rd(6'h20, 8'hc0, "size fields lowered");
    wr(6'h20, 8'hdb);
    rd(6'h20, 8'hc0, "size fields locked");
    for (int i = 0; i < 23; i++) begin
      ent = CMD_TAB[i];
      do_reset(ent[32:25], 1'b0, 1'b0);
      cmdchk(ent[23:1], ent[24], ent[0]);
      rd(6'h18, {3'b000, ent[0], 4'h0}, "violation flag");
      wr(6'h18, 8'h10);
      rd(6'h18, 8'h00, "violation flag cleared");
    end
    do_reset(8'hff, 1'b0, 1'b0);
    ev(4'b1100);
    rd(6'h1c, 8'h01, "single flag");
    wr(6'h1c, 8'h00);
    rd(6'h1c, 8'h01, "zero write keeps flag");
    wr(6'h1c, 8'hfe);
    rd(6'h1c, 8'h01, "unused flag bits");
    ev(4'b1010);
    rd(6'h1c, 8'h03, "double flag");
    wr(6'h14, 8'h03);
    repeat (2) @(posedge clock);
    chk("irq_double", 32'h1, {31'h0, irq_double});
    chk("irq_single", 32'h1, {31'h0, irq_single});
    wr(6'h1c, 8'h01);
    rd(6'h1c, 8'h02, "one write clears single");
    repeat (2) @(posedge clock);
    chk("irq_single off", 32'h0, {31'h0, irq_single});
    wr(6'h1c, 8'h02);
    rd(6'h1c, 8'h00, "one write clears double");
    repeat (2) @(posedge clock);
    chk("irq_double off", 32'h0, {31'h0, irq_double});
    wr(6'h10, 8'h10);
    ev(4'b1100);
    rd(6'h1c, 8'h00, "ignored single fault");
    ev(4'b1001);
    rd(6'h1c, 8'h02, "busy block read");
    wr(6'h10, 8'h00);
    ev(4'b1001);
    rd(6'h1c, 8'h03, "busy block sets both");
    rd(6'h3c, 8'h00, "unmapped read");
    wr(6'h21, 8'h00);
    rd(6'h21, 8'h00, "misaligned read");
    rd(6'h20, 8'hff, "misaligned write ignored");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
